// [core/aux_pkg.sv]
// Constants, register map and types of the auxiliary function handshake
// How it works
// RULE_01: Pending misc codes on slots, then strobe
// RULE_02: Per-code table picks before/after and wait
// RULE_03: Unlisted code: block start, await acknowledge
// RULE_04: Waiting group holds until acknowledge completes
// RULE_05: Non-waiting group strobes exactly one window
// RULE_06: Before group, motion, then after group
// RULE_07: Spindle code only with nonzero output type
// RULE_08: Spindle code at block start, acknowledged
// RULE_09: Tool code at block start, acknowledged
// RULE_10: Pocket code only in two magazine cases
// RULE_11: Tool change sends pocket code, acknowledged
// RULE_12: Strobes together share one acknowledge
// RULE_13: Controller drops acknowledge on seeing strobe
// RULE_14: Controller raises acknowledge when finished
// RULE_15: Acknowledge high beyond window drops strobes
// RULE_16: One window between strobe fall and rise
// RULE_17: Codes change only while strobes low
// RULE_18: Window timed by a cycle counter
package aux_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;
  localparam int ADDR_W = 8;
  localparam int M_SLOTS = 7;
  localparam int MIDX_W = 3;
  localparam int M_CODE_W = 8;
  localparam int S_CODE_W = 32;
  localparam int T_CODE_W = 16;
  localparam int WIN_W = 16;
  localparam int TBL_DEPTH = 8;
  localparam int TBL_IDX_W = 3;
  localparam int TBL_ENT_W = 11;
  localparam int CTRL_W = 5;
  localparam int BLK_W = 7;
  localparam int SPDL_W = 2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int MIN_WIN_NS = 100;
  localparam logic [WIN_W-1:0] MIN_WIN_CYC =
    WIN_W'((MIN_WIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_WIN = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_BLOCK = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_SPEED = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_MSLOT = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_TOOL = 8'h2C;
  localparam logic [ADDR_W-1:0] OFS_POCKET = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_GO = 8'h34;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h38;
  localparam logic [ADDR_W-1:0] OFS_TABLE = 8'h40;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_SPDL_LSB = 0;
  localparam int CTRL_TC_CMD = 2;
  localparam int CTRL_RANDOM = 3;
  localparam int CTRL_SPECIAL = 4;
  localparam int BLK_MCNT_LSB = 0;
  localparam int BLK_HAS_S = 3;
  localparam int BLK_HAS_T = 4;
  localparam int BLK_HAS_TC = 5;
  localparam int BLK_MOTION = 6;
  localparam int GO_START = 0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ACK = 1;
  localparam int STAT_MOTION = 2;
  localparam int STAT_POST = 3;
  localparam int TBL_CODE_LSB = 0;
  localparam int TBL_AFTER = 8;
  localparam int TBL_WAIT = 9;
  localparam int TBL_VALID = 10;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_GAP,
    ST_STROBE,
    ST_MOTION
  } seq_state_t;

endpackage

// [core/aux_if.sv]
// Interfaces between the sequencer, its window timers and function table
`timescale 1ns/1ps
interface win_timer_if;
  import aux_pkg::*;
  logic [WIN_W-1:0] cnt;
  logic clr;
  modport timer (input clr, output cnt);
  modport user (output clr, input cnt);
endinterface

interface m_table_if;
  import aux_pkg::*;
  logic wr_en;
  logic [TBL_IDX_W-1:0] wr_idx;
  logic [TBL_ENT_W-1:0] wr_data;
  logic [TBL_DEPTH-1:0][TBL_ENT_W-1:0] ent;
  logic [M_SLOTS-1:0][M_CODE_W-1:0] code;
  logic [M_SLOTS-1:0] hit;
  logic [M_SLOTS-1:0] after;
  logic [M_SLOTS-1:0] wait_ack;
  modport table_side (input wr_en, wr_idx, wr_data, code,
                      output ent, hit, after, wait_ack);
  modport user (output wr_en, wr_idx, wr_data, code,
                input ent, hit, after, wait_ack);
endinterface

// [core/win_timer.sv]
// Saturating cycle counter used to time the minimum window
`timescale 1ns/1ps
module win_timer (
  input wire logic ref_clk,
  input wire logic rst,
  win_timer_if.timer tm
);
  import aux_pkg::*;

  typedef struct packed {
    logic [WIN_W-1:0] cnt;
  } tmr_state_t;

  tmr_state_t s_r;
  tmr_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (tm.clr) begin
      s_nxt.cnt = '0;
    end else if (s_r.cnt != '1) begin
      s_nxt.cnt = s_r.cnt + 1'b1; // RULE_18
    end
  end

  // Starts saturated so the first strobe after reset needs no gap
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_r.cnt <= '1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tm.cnt = s_r.cnt;
endmodule // win_timer

// [core/m_table.sv]
// Function table: per-code timing and acknowledge policy, looked up per slot
`timescale 1ns/1ps
module m_table (
  input wire logic ref_clk,
  input wire logic rst,
  m_table_if.table_side tb
);
  import aux_pkg::*;

  typedef struct packed {
    logic [TBL_DEPTH-1:0][TBL_ENT_W-1:0] ent;
  } tbl_state_t;

  tbl_state_t s_r;
  tbl_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (tb.wr_en) begin
      s_nxt.ent[tb.wr_idx] = tb.wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tb.ent = s_r.ent;

  // Lowest matching entry wins on duplicate codes
  for (genvar g = 0; g < M_SLOTS; g++) begin : g_slot
    logic hit_g;
    logic after_g;
    logic wait_g;
    always_comb begin
      hit_g = 1'b0;
      after_g = 1'b0;
      wait_g = 1'b0;
      for (int e = TBL_DEPTH - 1; e >= 0; e--) begin
        if (s_r.ent[e][TBL_VALID] &&
            s_r.ent[e][TBL_CODE_LSB +: M_CODE_W] == tb.code[g]) begin
          hit_g = 1'b1; // RULE_02
          after_g = s_r.ent[e][TBL_AFTER];
          wait_g = s_r.ent[e][TBL_WAIT];
        end
      end
    end
    assign tb.hit[g] = hit_g;
    assign tb.after[g] = after_g;
    assign tb.wait_ack[g] = wait_g;
  end
endmodule // m_table

// [core/aux_handshake.sv]
// Sequencer of auxiliary function transfer with its AXI4-Lite registers
`timescale 1ns/1ps
module aux_handshake (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [aux_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [aux_pkg::DATA_W-1:0] wdata,
  input wire logic [aux_pkg::STRB_W-1:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [aux_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [aux_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic [aux_pkg::M_SLOTS-1:0][aux_pkg::M_CODE_W-1:0] misc_code_slot,
  output logic misc_code_valid,
  output logic [aux_pkg::S_CODE_W-1:0] spindle_speed_code,
  output logic spindle_code_valid,
  output logic [aux_pkg::T_CODE_W-1:0] tool_number_code,
  output logic tool_code_valid,
  output logic [aux_pkg::T_CODE_W-1:0] empty_pocket_code,
  output logic pocket_code_valid,
  input wire logic aux_done_ack,
  output logic motion_req,
  input wire logic motion_done
);
  import aux_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    seq_state_t st;
    logic post;
    logic grp_wait;
    logic ack_low_seen;
    logic pend_m;
    logic pend_s;
    logic pend_t;
    logic pend_t2;
    logic [CTRL_W-1:0] ctrl;
    logic [WIN_W-1:0] win;
    logic [BLK_W-1:0] blk;
    logic [S_CODE_W-1:0] speed;
    logic [M_SLOTS-1:0][M_CODE_W-1:0] mprog;
    logic [T_CODE_W-1:0] tool;
    logic [T_CODE_W-1:0] pocket;
    logic [M_SLOTS-1:0][M_CODE_W-1:0] m_out;
    logic m_v;
    logic [S_CODE_W-1:0] s_out;
    logic s_v;
    logic [T_CODE_W-1:0] t_out;
    logic t_v;
    logic [T_CODE_W-1:0] t2_out;
    logic t2_v;
    logic motion_req;
    logic aw_have;
    logic [ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [DATA_W-1:0] w_data;
    logic [STRB_W-1:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } core_state_t;

  core_state_t s_r;
  core_state_t s_nxt;

  win_timer_if hold_if ();
  win_timer_if gap_if ();
  m_table_if tbl_if ();

  win_timer u_hold (
    .ref_clk(ref_clk),
    .rst(rst),
    .tm(hold_if.timer)
  );

  win_timer u_gap (
    .ref_clk(ref_clk),
    .rst(rst),
    .tm(gap_if.timer)
  );

  m_table u_table (
    .ref_clk(ref_clk),
    .rst(rst),
    .tb(tbl_if.table_side)
  );

  // ----------------------------------------------------------------
  // Register access helpers
  // ----------------------------------------------------------------
  function automatic logic [DATA_W-1:0] merge_bytes(
      input logic [DATA_W-1:0] old,
      input logic [DATA_W-1:0] d,
      input logic [STRB_W-1:0] st);
    logic [DATA_W-1:0] r;
    r = old;
    for (int b = 0; b < STRB_W; b++) begin
      if (st[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Word index of a in an array of n words at base, or n when outside
  function automatic int arr_idx(
      input logic [ADDR_W-1:0] a,
      input logic [ADDR_W-1:0] base,
      input int n);
    logic [ADDR_W-1:0] off;
    int i;
    off = a - base;
    i = int'(off[ADDR_W-1:2]);
    if (a < base || i >= n) begin
      i = n;
    end
    return i;
  endfunction

  // Bit DATA_W flags a mapped address
  function automatic logic [DATA_W:0] read_word(
      input logic [ADDR_W-1:0] a,
      input core_state_t st,
      input logic ack,
      input logic [TBL_DEPTH-1:0][TBL_ENT_W-1:0] ents);
    logic [DATA_W:0] r;
    int mi;
    int ti;
    r = '0;
    r[DATA_W] = 1'b1;
    mi = arr_idx(a, OFS_MSLOT, M_SLOTS);
    ti = arr_idx(a, OFS_TABLE, TBL_DEPTH);
    if (a == OFS_CTRL) begin
      r[CTRL_W-1:0] = st.ctrl;
    end else if (a == OFS_WIN) begin
      r[WIN_W-1:0] = st.win;
    end else if (a == OFS_BLOCK) begin
      r[BLK_W-1:0] = st.blk;
    end else if (a == OFS_SPEED) begin
      r[S_CODE_W-1:0] = st.speed;
    end else if (a == OFS_TOOL) begin
      r[T_CODE_W-1:0] = st.tool;
    end else if (a == OFS_POCKET) begin
      r[T_CODE_W-1:0] = st.pocket;
    end else if (a == OFS_GO) begin
      r[GO_START] = 1'b0;
    end else if (a == OFS_STATUS) begin
      r[STAT_BUSY] = (st.st != ST_IDLE);
      r[STAT_ACK] = ack;
      r[STAT_MOTION] = st.motion_req;
      r[STAT_POST] = st.post;
    end else if (mi < M_SLOTS) begin
      r[M_CODE_W-1:0] = st.mprog[mi];
    end else if (ti < TBL_DEPTH) begin
      r[TBL_ENT_W-1:0] = ents[ti];
    end else begin
      r[DATA_W] = 1'b0;
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [M_SLOTS-1:0] sel;
    logic [M_SLOTS-1:0][M_CODE_W-1:0] packed_codes;
    logic [MIDX_W-1:0] mcnt;
    logic [WIN_W-1:0] win_m1;
    logic [DATA_W:0] rv;
    logic [DATA_W-1:0] wv;
    logic [ADDR_W-1:0] wa;
    logic want_post;
    logic after_fn;
    logic m_wait;
    logic s_go;
    logic t_go;
    logic t2_go;
    logic grp_any;
    logic grp_wait;
    logic start;
    logic idle;
    logic drop;
    int k;
    int mi;
    int ti;
    sel = '0;
    packed_codes = '0;
    mcnt = s_r.blk[BLK_MCNT_LSB +: MIDX_W];
    win_m1 = (s_r.win == '0) ? '0 : s_r.win - 1'b1;
    rv = '0;
    wv = '0;
    wa = {s_r.aw_addr[ADDR_W-1:2], 2'h0};
    want_post = (s_r.st == ST_MOTION);
    after_fn = 1'b0;
    m_wait = 1'b0;
    start = 1'b0;
    idle = (s_r.st == ST_IDLE);
    drop = 1'b0;
    k = 0;
    mi = 0;
    ti = 0;
    s_nxt = s_r;
    tbl_if.wr_en = 1'b0;
    tbl_if.wr_idx = '0;
    tbl_if.wr_data = '0;
    tbl_if.code = s_r.mprog;

    // --------------------------------------------------------------
    // AXI4-Lite write channel
    // --------------------------------------------------------------
    if (awvalid && s_r.awready) begin
      s_nxt.aw_have = 1'b1;
      s_nxt.aw_addr = awaddr;
    end
    if (wvalid && s_r.wready) begin
      s_nxt.w_have = 1'b1;
      s_nxt.w_data = wdata;
      s_nxt.w_strb = wstrb;
    end
    if (s_r.bvalid && bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.aw_have && s_r.w_have && !s_r.bvalid) begin
      rv = read_word(wa, s_r, aux_done_ack, tbl_if.ent);
      wv = merge_bytes(rv[DATA_W-1:0], s_r.w_data, s_r.w_strb);
      mi = arr_idx(wa, OFS_MSLOT, M_SLOTS);
      ti = arr_idx(wa, OFS_TABLE, TBL_DEPTH);
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = rv[DATA_W] ? RESP_OKAY : RESP_SLVERR;
      // Block contents are frozen while a block runs
      if (wa == OFS_CTRL) begin
        s_nxt.ctrl = wv[CTRL_W-1:0];
      end else if (wa == OFS_WIN) begin
        s_nxt.win = wv[WIN_W-1:0]; // RULE_18
      end else if (wa == OFS_BLOCK && idle) begin
        s_nxt.blk = wv[BLK_W-1:0];
      end else if (wa == OFS_SPEED && idle) begin
        s_nxt.speed = wv[S_CODE_W-1:0];
      end else if (wa == OFS_TOOL && idle) begin
        s_nxt.tool = wv[T_CODE_W-1:0];
      end else if (wa == OFS_POCKET && idle) begin
        s_nxt.pocket = wv[T_CODE_W-1:0];
      end else if (wa == OFS_GO) begin
        start = wv[GO_START] && idle;
      end else if (mi < M_SLOTS && idle) begin
        s_nxt.mprog[mi] = wv[M_CODE_W-1:0];
      end else if (ti < TBL_DEPTH) begin
        tbl_if.wr_en = 1'b1;
        tbl_if.wr_idx = TBL_IDX_W'(ti);
        tbl_if.wr_data = wv[TBL_ENT_W-1:0];
      end
    end
    s_nxt.awready = !s_nxt.aw_have && !s_nxt.bvalid;
    s_nxt.wready = !s_nxt.w_have && !s_nxt.bvalid;

    // --------------------------------------------------------------
    // AXI4-Lite read channel
    // --------------------------------------------------------------
    if (s_r.rvalid && rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (arvalid && s_r.arready) begin
      rv = read_word({araddr[ADDR_W-1:2], 2'h0}, s_r, aux_done_ack,
                     tbl_if.ent);
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rv[DATA_W-1:0];
      s_nxt.rresp = rv[DATA_W] ? RESP_OKAY : RESP_SLVERR;
    end
    s_nxt.arready = !s_nxt.rvalid;

    // --------------------------------------------------------------
    // Group selection for the phase about to be loaded
    // --------------------------------------------------------------
    for (int i = 0; i < M_SLOTS; i++) begin
      if (MIDX_W'(i) < mcnt) begin
        after_fn = tbl_if.hit[i] && tbl_if.after[i]; // RULE_02 RULE_03
        sel[i] = want_post ? after_fn : !after_fn; // RULE_06
        if (sel[i] && (!tbl_if.hit[i] || tbl_if.wait_ack[i])) begin
          m_wait = 1'b1; // RULE_03
        end
      end
    end
    for (int i = 0; i < M_SLOTS; i++) begin
      if (sel[i]) begin
        packed_codes[k] = s_r.mprog[i]; // RULE_01
        k++;
      end
    end
    s_go = !want_post && s_r.blk[BLK_HAS_S] &&
           (s_r.ctrl[CTRL_SPDL_LSB +: SPDL_W] != '0); // RULE_07
    t_go = !want_post && s_r.blk[BLK_HAS_T]; // RULE_09
    t2_go = !want_post && s_r.blk[BLK_HAS_TC] &&
            ((s_r.ctrl[CTRL_TC_CMD] && !s_r.ctrl[CTRL_RANDOM]) ||
             (s_r.ctrl[CTRL_RANDOM] && s_r.ctrl[CTRL_SPECIAL])); // RULE_10
    grp_any = (|sel) || s_go || t_go || t2_go;
    grp_wait = m_wait || s_go || t_go || t2_go; // RULE_08 RULE_11

    // --------------------------------------------------------------
    // Sequencer
    // --------------------------------------------------------------
    unique case (s_r.st)
      ST_IDLE: begin
        if (start) begin
          s_nxt.post = 1'b0;
          if (grp_any) begin
            s_nxt.st = ST_GAP;
          end else begin
            s_nxt.st = ST_MOTION;
            s_nxt.motion_req = s_r.blk[BLK_MOTION];
          end
        end
      end
      ST_GAP: begin
        if (gap_if.cnt >= win_m1) begin
          s_nxt.m_v = s_r.pend_m; // RULE_01 RULE_12
          s_nxt.s_v = s_r.pend_s;
          s_nxt.t_v = s_r.pend_t;
          s_nxt.t2_v = s_r.pend_t2;
          s_nxt.ack_low_seen = 1'b0;
          s_nxt.st = ST_STROBE;
        end
      end
      ST_STROBE: begin
        if (!aux_done_ack) begin
          s_nxt.ack_low_seen = 1'b1; // RULE_13
        end
        if (s_r.grp_wait) begin
          drop = s_r.ack_low_seen && aux_done_ack &&
                 (hold_if.cnt >= s_r.win); // RULE_04 RULE_14 RULE_15
        end else begin
          drop = (hold_if.cnt >= win_m1); // RULE_05
        end
        if (drop) begin
          s_nxt.m_v = 1'b0; // RULE_15
          s_nxt.s_v = 1'b0;
          s_nxt.t_v = 1'b0;
          s_nxt.t2_v = 1'b0;
          if (s_r.post) begin
            s_nxt.st = ST_IDLE;
          end else begin
            s_nxt.st = ST_MOTION; // RULE_06
            s_nxt.motion_req = s_r.blk[BLK_MOTION];
          end
        end
      end
      ST_MOTION: begin
        if (!s_r.motion_req || motion_done) begin
          s_nxt.motion_req = 1'b0;
          s_nxt.post = 1'b1;
          s_nxt.st = grp_any ? ST_GAP : ST_IDLE; // RULE_06
        end
      end
    endcase

    // Codes load only on entry to the gap, while every strobe is low
    if (s_nxt.st == ST_GAP && s_r.st != ST_GAP) begin
      s_nxt.m_out = packed_codes; // RULE_17
      s_nxt.pend_m = |sel;
      s_nxt.pend_s = s_go;
      s_nxt.pend_t = t_go;
      s_nxt.pend_t2 = t2_go;
      s_nxt.grp_wait = grp_wait;
      if (s_go) begin
        s_nxt.s_out = s_r.speed; // RULE_08
      end
      if (t_go) begin
        s_nxt.t_out = s_r.tool; // RULE_09
      end
      if (t2_go) begin
        s_nxt.t2_out = s_r.pocket; // RULE_11
      end
    end

    // Hold timer restarts on strobe rise and on every low acknowledge of a waiting group
    hold_if.clr = (s_r.st != ST_STROBE) ||
                  (s_r.grp_wait && !aux_done_ack); // RULE_18
    gap_if.clr = drop; // RULE_16
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
      s_r.win <= MIN_WIN_CYC;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign awready = s_r.awready;
  assign wready = s_r.wready;
  assign bresp = s_r.bresp;
  assign bvalid = s_r.bvalid;
  assign arready = s_r.arready;
  assign rdata = s_r.rdata;
  assign rresp = s_r.rresp;
  assign rvalid = s_r.rvalid;
  assign misc_code_slot = s_r.m_out;
  assign misc_code_valid = s_r.m_v;
  assign spindle_speed_code = s_r.s_out;
  assign spindle_code_valid = s_r.s_v;
  assign tool_number_code = s_r.t_out;
  assign tool_code_valid = s_r.t_v;
  assign empty_pocket_code = s_r.t2_out;
  assign pocket_code_valid = s_r.t2_v;
  assign motion_req = s_r.motion_req;

endmodule // aux_handshake

// [verif/aux_handshake_props.sv]
// Port timing checker of the auxiliary function handshake
`timescale 1ns/1ps
module aux_handshake_props
  import aux_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic [M_SLOTS-1:0][M_CODE_W-1:0] misc_code_slot,
  input wire logic misc_code_valid,
  input wire logic spindle_code_valid,
  input wire logic [T_CODE_W-1:0] tool_number_code,
  input wire logic tool_code_valid,
  input wire logic pocket_code_valid,
  input wire logic aux_done_ack,
  input wire logic motion_req
);
  logic any_on;
  logic wait_on;
  assign wait_on = spindle_code_valid | tool_code_valid | pocket_code_valid;
  assign any_on = misc_code_valid | wait_on;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ------
  // Window of 2 cycles, as the bench programs it
  // ------
  sequence low_gap;
    !any_on [*2];
  endsequence
  sequence high_hold;
    any_on [*2];
  endsequence
  a_codes_stable: assert property (any_on && $past(any_on) |->
    $stable(misc_code_slot) && $stable(tool_number_code))
    else $error("code changed under strobe");
  a_fall_together: assert property ($fell(misc_code_valid) ||
    $fell(tool_code_valid) || $fell(spindle_code_valid) ||
    $fell(pocket_code_valid) |-> !any_on) else $error("strobes fell apart");
  a_gap_min: assert property ($fell(any_on) |-> low_gap)
    else $error("strobe gap too short");
  a_hold_min: assert property ($rose(any_on) |-> high_hold)
    else $error("strobe shorter than window");
  a_ack_gates: assert property (wait_on && !aux_done_ack |=> wait_on)
    else $error("strobe dropped without ack");
  a_ack_held: assert property ($fell(wait_on) |-> $past(aux_done_ack) &&
    $past(aux_done_ack, 2) && $past(aux_done_ack, 3))
    else $error("ack not held long enough");
  a_motion_excl: assert property (motion_req |-> !any_on)
    else $error("strobe during motion");
  a_bvalid_hold: assert property (bvalid && !bready |=>
    bvalid && $stable(bresp)) else $error("write response lost");
  a_write_resp: assert property (awvalid && awready && wvalid && wready
    |-> ##2 bvalid) else $error("write response late");
  a_read_resp: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read response late");
endmodule // aux_handshake_props

bind aux_handshake aux_handshake_props props (.ref_clk, .rst, .awvalid,
  .awready, .wvalid, .wready, .bvalid, .bready, .bresp, .arvalid, .arready,
  .rvalid, .misc_code_slot, .misc_code_valid, .spindle_code_valid,
  .tool_number_code, .tool_code_valid, .pocket_code_valid, .aux_done_ack,
  .motion_req);

// [verif/plc_model.sv]
// Logic controller model answering strobes with the done acknowledge
`timescale 1ns/1ps
module plc_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] strobes,
  input wire logic slow,
  output logic aux_done_ack
);
  // Count 15 marks work finished; ack then holds until strobes drop
  logic [3:0] cnt;
  always @(posedge ref_clk) begin
    if (rst) begin
      aux_done_ack <= 1'h1;
      cnt <= 4'h0;
    end else if (strobes == 4'h0) begin
      aux_done_ack <= 1'h1;
      cnt <= 4'h0;
    end else if (cnt == 4'h0) begin
      aux_done_ack <= 1'h0;
      cnt <= slow ? 4'h9 : 4'h2;
    end else if (cnt == 4'h1) begin
      aux_done_ack <= 1'h1;
      cnt <= 4'hf;
    end else if (cnt != 4'hf) begin
      cnt <= cnt - 4'h1;
    end
  end
endmodule // plc_model

// [verif/aux_handshake_tb.sv]
// Self-checking bench of the auxiliary function handshake
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, (a), (b)); end end
module aux_handshake_tb;
  import aux_pkg::*;
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic [ADDR_W-1:0] awaddr = 8'h00, araddr = 8'h00;
  logic [DATA_W-1:0] wdata = 32'h0000_0000, rdata;
  logic [STRB_W-1:0] wstrb = 4'hf;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0, motion_done = 1'h0, slow = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, aux_done_ack, motion_req;
  logic [1:0] bresp, rresp, resp;
  logic [M_SLOTS-1:0][M_CODE_W-1:0] misc_code_slot;
  logic misc_code_valid, spindle_code_valid, tool_code_valid;
  logic pocket_code_valid;
  logic [S_CODE_W-1:0] spindle_speed_code;
  logic [T_CODE_W-1:0] tool_number_code, empty_pocket_code, tl, pk;
  logic [31:0] rd, spd, ctl;
  logic [3:0] stb, e;
  int num_errors = 0, checked = 0, cycles = 0, n;
  assign stb = {pocket_code_valid, tool_code_valid, spindle_code_valid,
    misc_code_valid};
  aux_handshake dut (.ref_clk, .rst, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .misc_code_slot,
    .misc_code_valid, .spindle_speed_code, .spindle_code_valid,
    .tool_number_code, .tool_code_valid, .empty_pocket_code,
    .pocket_code_valid, .aux_done_ack, .motion_req, .motion_done);
  plc_model plc (.ref_clk, .rst, .strobes(stb), .slow, .aux_done_ack);
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  // ------
  // Bus and group helpers
  // ------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'h0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rd = rdata;
    resp = rresp;
    rready <= 1'h0;
  endtask
  task automatic grp(input logic [3:0] ex, input logic [7:0] m0,
                     output int hi);
    do @(posedge ref_clk); while (stb == 4'h0);
    `CHK(stb, ex)
    if (ex[0]) `CHK(misc_code_slot[0], m0)
    hi = 0;
    do begin
      hi++;
      @(posedge ref_clk);
    end while (stb != 4'h0);
  endtask
  function automatic logic [3:0] expect_grp(input logic [4:0] c);
    logic p;
    p = (c[2] & ~c[3]) | (c[3] & c[4]);
    return {p, 1'h1, c[1:0] != 2'h0, 1'h1};
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(48258));
    repeat (3) @(posedge ref_clk);
    rst <= 1'h0;
    @(posedge ref_clk);
    `CHK(stb, 4'h0)
    rdr(OFS_WIN);
    `CHK(rd, {16'h0000, MIN_WIN_CYC})
    rdr(8'h3C);
    `CHK(resp, RESP_SLVERR)
    wr(8'h3C, 32'h0000_0001);
    `CHK(resp, RESP_SLVERR)
    wr(OFS_WIN, 32'h0000_0002);
    wr(OFS_TABLE, 32'h0000_0433);
    wr(OFS_TABLE + 8'h04, 32'h0000_053D);
    wr(OFS_MSLOT, 32'h0000_0033);
    wr(OFS_MSLOT + 8'h04, 32'h0000_003D);
    for (int mv = 0; mv < 2; mv++) begin
      wr(OFS_BLOCK, mv ? 32'h0000_0042 : 32'h0000_0002);
      wr(OFS_GO, 32'h0000_0001);
      grp(4'h1, 8'h33, n);
      `CHK(n, 2)
      if (mv) begin
        do @(posedge ref_clk); while (!motion_req);
        `CHK(stb, 4'h0)
        motion_done <= 1'h1;
        @(posedge ref_clk);
        motion_done <= 1'h0;
      end
      grp(4'h1, 8'h3D, n);
    end
    for (int it = 0; it < 6; it++) begin
      ctl = $urandom;
      if (it < 3) ctl[4:0] = (it == 0) ? 5'h04 : (it == 1) ? 5'h19 : 5'h0b;
      spd = $urandom;
      tl = 16'($urandom);
      pk = 16'($urandom);
      slow <= ctl[8];
      wr(OFS_CTRL, {27'h0, ctl[4:0]});
      wr(OFS_SPEED, spd);
      wr(OFS_TOOL, {16'h0000, tl});
      wr(OFS_POCKET, {16'h0000, pk});
      wr(OFS_MSLOT, 32'h0000_0063);
      wr(OFS_BLOCK, 32'h0000_0039);
      wr(OFS_GO, 32'h0000_0001);
      e = expect_grp(ctl[4:0]);
      grp(e, 8'h63, n);
      if (e[1]) `CHK(spindle_speed_code, spd)
      `CHK(tool_number_code, tl)
      if (e[3]) `CHK(empty_pocket_code, pk)
    end
    tally_and_finish();
  end
endmodule // aux_handshake_tb
